/* File: ddr_cfg.svh */
// address map, group layout and register indices of the distributed channel redirect
`ifndef DDR_CFG_SVH
`define DDR_CFG_SVH
`define DDR_CH0_ADDR_PORT 16'h0000
`define DDR_CH0_COUNT_PORT 16'h0001
`define DDR_CH1_ADDR_PORT 16'h0002
`define DDR_CH1_COUNT_PORT 16'h0003
`define DDR_CH2_ADDR_PORT 16'h0004
`define DDR_CH2_COUNT_PORT 16'h0005
`define DDR_CH3_ADDR_PORT 16'h0006
`define DDR_CH3_COUNT_PORT 16'h0007
`define DDR_CH2_UPPER_PORT 16'h0081
`define DDR_CH3_UPPER_PORT 16'h0082
`define DDR_CH1_UPPER_PORT 16'h0083
`define DDR_CH0_UPPER_PORT 16'h0087
`define DDR_CH6_UPPER_PORT 16'h0089
`define DDR_CH7_UPPER_PORT 16'h008a
`define DDR_CH5_UPPER_PORT 16'h008b
`define DDR_CH5_ADDR_PORT 16'h00c4
`define DDR_CH5_COUNT_PORT 16'h00c6
`define DDR_CH6_ADDR_PORT 16'h00c8
`define DDR_CH6_COUNT_PORT 16'h00ca
`define DDR_CH7_ADDR_PORT 16'h00cc
`define DDR_CH7_COUNT_PORT 16'h00ce
`define DDR_GROUP_ALIGN_BITS 6
`define DDR_CHAN_STRIDE_BITS 4
`define DDR_IDX_ADDR 4'h0
`define DDR_IDX_COUNT 4'h2
`define DDR_IDX_UPPER 4'h4
`define DDR_MASK_WORD 16'hffff
`define DDR_MASK_BYTE 16'h00ff
`define DDR_LOCAL_CHAN 3'h4
`endif

/* File: ddr_pkg.sv */
// types shared by the distributed channel redirect
package ddr_pkg;
    typedef enum logic [1:0] {
        DDR_KIND_ADDR,
        DDR_KIND_COUNT,
        DDR_KIND_UPPER
    } ddr_kind_t;

    typedef struct packed {
        logic hit;
        ddr_kind_t kind;
        logic [2:0] chan;
    } ddr_decode_t;

    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] data;
    } ddr_access_t;

    typedef enum {
        DDR_IDLE,
        DDR_LEG_DIRECT,
        DDR_LEG_MERGE,
        DDR_BUS_REQ,
        DDR_FORWARD,
        DDR_HOLD
    } ddr_state_t;
endpackage

/* File: ddr_redirect.sv */
// distributed channel redirect: retries distributed processor accesses and forwards them to peripherals
// Notes on behaviour
// - distributed read first answered with retry
// - distributed write retried before any forwarding
// - request bus, forward only after grant
// - forward address from pointer, channel, index
// - merge forwarded read data with local value
// - repeated read returns the constructed value
// - forwarded write data comes from processor
// - repeated write completes without more forwarding
// - channel four always stays local
// - address port write forwarded as word
// - address ports decoded at their fixed addresses
// - count port write forwarded as word
// - count ports decoded at their fixed addresses
// - base registers readable during state save
// - upper address access forwarded as byte
// - upper address ports decoded at fixed addresses
// - current address read forwarded once
// - current count read forwarded once
// - current count reads share count ports
// - groups on 64-byte pointer, 16-byte stride
// - state save mode bypasses forwarding entirely
// - distributed channels chosen by configuration bits
`timescale 1ns/100ps
`include "ddr_cfg.svh"

module ddr_redirect (
    input wire logic clock,                      // 200 MHz clock
    input wire logic rst_n,                      // asynchronous reset, active low
    input wire logic tgt_valid,                  // processor access offered this cycle
    input wire ddr_pkg::ddr_access_t tgt_req,    // processor access
    output ddr_pkg::ddr_access_t dbg_unused_n,   // spare, held at zero
    output logic tgt_retry_q,                    // access ends with retry
    output logic tgt_done_q,                     // access completes
    output logic [15:0] tgt_rdata_q,             // read data with done
    input wire logic [7:0] dist_en,              // per channel distributed select
    input wire logic [15:6] ptr_low,             // group pointer, channels 0-3
    input wire logic [15:6] ptr_high,            // group pointer, channels 5-7
    input wire logic alt_access,                 // state save access mode
    output logic bus_req_q,                      // request bus ownership
    input wire logic bus_gnt,                    // bus granted
    output logic fwd_valid_q,                    // forwarded cycle pending
    output ddr_pkg::ddr_access_t fwd_q,          // forwarded cycle
    input wire logic fwd_ack,                    // forwarded cycle finished
    input wire logic [15:0] fwd_rdata,           // forwarded read data
    output logic leg_valid_q,                    // local controller access pending
    output ddr_pkg::ddr_access_t leg_q,          // local controller access
    input wire logic leg_ack,                    // local access finished
    input wire logic [15:0] leg_rdata            // local read data
);
    import ddr_pkg::*;

    function automatic ddr_decode_t decode(input logic [15:0] a);
        ddr_decode_t d;
        d = '0;
        d.hit = 1'b1;
        case (a)
            `DDR_CH0_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h0; end
            `DDR_CH1_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h1; end
            `DDR_CH2_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h2; end
            `DDR_CH3_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h3; end
            `DDR_CH5_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h5; end
            `DDR_CH6_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h6; end
            `DDR_CH7_ADDR_PORT: begin d.kind = DDR_KIND_ADDR; d.chan = 3'h7; end
            `DDR_CH0_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h0; end
            `DDR_CH1_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h1; end
            `DDR_CH2_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h2; end
            `DDR_CH3_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h3; end
            `DDR_CH5_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h5; end
            `DDR_CH6_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h6; end
            `DDR_CH7_COUNT_PORT: begin d.kind = DDR_KIND_COUNT; d.chan = 3'h7; end
            `DDR_CH0_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h0; end
            `DDR_CH1_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h1; end
            `DDR_CH2_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h2; end
            `DDR_CH3_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h3; end
            `DDR_CH5_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h5; end
            `DDR_CH6_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h6; end
            `DDR_CH7_UPPER_PORT: begin d.kind = DDR_KIND_UPPER; d.chan = 3'h7; end
            default: d.hit = 1'b0;
        endcase
        return d;
    endfunction

    // peripheral I/O address of a channel register
    function automatic logic [15:0] fwd_addr(input ddr_decode_t d, input logic [15:6] lo,
                                             input logic [15:6] hi);
        logic [1:0] slot;
        logic [3:0] idx;
        logic [15:0] base;
        slot = d.chan[2] ? 2'(d.chan[1:0] - 2'h1) : d.chan[1:0];
        base = d.chan[2] ? {hi, 6'h00} : {lo, 6'h00};
        case (d.kind)
            DDR_KIND_ADDR: idx = `DDR_IDX_ADDR;
            DDR_KIND_COUNT: idx = `DDR_IDX_COUNT;
            DDR_KIND_UPPER: idx = `DDR_IDX_UPPER;
            default: idx = `DDR_IDX_ADDR;
        endcase
        return base | {10'h000, slot, idx};
    endfunction

    function automatic logic [15:0] width_mask(input ddr_decode_t d);
        return (d.kind == DDR_KIND_UPPER) ? `DDR_MASK_BYTE : `DDR_MASK_WORD;
    endfunction

    ddr_state_t state_q, state_d;
    ddr_access_t held_q, held_d;
    ddr_decode_t dec_q, dec_d;
    logic [15:0] local_q, local_d;
    logic [15:0] merged_q, merged_d;
    logic tgt_retry_d, tgt_done_d, bus_req_d, fwd_valid_d, leg_valid_d;
    logic [15:0] tgt_rdata_d;
    ddr_access_t fwd_d, leg_d;
    ddr_decode_t in_dec;
    logic in_dist, repeat_hit;

    always_comb begin
        in_dec = decode(tgt_req.addr);
        // state save mode keeps accesses local
        in_dist = in_dec.hit && dist_en[in_dec.chan] && (in_dec.chan != `DDR_LOCAL_CHAN)
            && !alt_access;
        repeat_hit = tgt_valid && (tgt_req.addr == held_q.addr)
            && (tgt_req.write == held_q.write);
        state_d = state_q;
        held_d = held_q;
        dec_d = dec_q;
        local_d = local_q;
        merged_d = merged_q;
        tgt_retry_d = 1'b0;
        tgt_done_d = 1'b0;
        tgt_rdata_d = tgt_rdata_q;
        bus_req_d = bus_req_q;
        fwd_valid_d = fwd_valid_q;
        fwd_d = fwd_q;
        leg_valid_d = leg_valid_q;
        leg_d = leg_q;
        case (state_q)
            DDR_IDLE: begin
                if (tgt_valid && in_dist) begin
                    tgt_retry_d = 1'b1;
                    held_d = tgt_req;
                    dec_d = in_dec;
                    if (tgt_req.write) begin
                        bus_req_d = 1'b1;
                        state_d = DDR_BUS_REQ;
                    end else begin
                        leg_valid_d = 1'b1;
                        leg_d = tgt_req;
                        state_d = DDR_LEG_MERGE;
                    end
                end else if (tgt_valid && in_dec.hit) begin
                    held_d = tgt_req;
                    leg_valid_d = 1'b1;
                    leg_d = tgt_req;
                    state_d = DDR_LEG_DIRECT;
                end
            end
            DDR_LEG_DIRECT: begin
                if (leg_ack) begin
                    leg_valid_d = 1'b0;
                    tgt_done_d = 1'b1;
                    tgt_rdata_d = held_q.write ? 16'h0000 : leg_rdata;
                    state_d = DDR_IDLE;
                end
            end
            DDR_LEG_MERGE: begin
                tgt_retry_d = tgt_valid;
                if (leg_ack) begin
                    leg_valid_d = 1'b0;
                    local_d = leg_rdata;
                    bus_req_d = 1'b1;
                    state_d = DDR_BUS_REQ;
                end
            end
            DDR_BUS_REQ: begin
                tgt_retry_d = tgt_valid;
                if (bus_gnt) begin
                    fwd_valid_d = 1'b1;
                    fwd_d.addr = fwd_addr(dec_q, ptr_low, ptr_high);
                    fwd_d.write = held_q.write;
                    fwd_d.data = held_q.write ? held_q.data : 16'h0000;
                    state_d = DDR_FORWARD;
                end
            end
            DDR_FORWARD: begin
                tgt_retry_d = tgt_valid;
                if (fwd_ack) begin
                    fwd_valid_d = 1'b0;
                    bus_req_d = 1'b0;
                    merged_d = (fwd_rdata & width_mask(dec_q))
                        | (local_q & ~width_mask(dec_q));
                    state_d = DDR_HOLD;
                end
            end
            DDR_HOLD: begin
                if (repeat_hit) begin
                    tgt_done_d = 1'b1;
                    tgt_rdata_d = held_q.write ? 16'h0000 : merged_q;
                    state_d = DDR_IDLE;
                end else begin
                    tgt_retry_d = tgt_valid;
                end
            end
            default: begin
                state_d = DDR_IDLE;
                bus_req_d = 1'b0;
                fwd_valid_d = 1'b0;
                leg_valid_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= DDR_IDLE;
            dbg_unused_n <= '0;
            held_q <= '0;
            dec_q <= '0;
            local_q <= 16'h0000;
            merged_q <= 16'h0000;
            tgt_retry_q <= 1'b0;
            tgt_done_q <= 1'b0;
            tgt_rdata_q <= 16'h0000;
            bus_req_q <= 1'b0;
            fwd_valid_q <= 1'b0;
            fwd_q <= '0;
            leg_valid_q <= 1'b0;
            leg_q <= '0;
        end else begin
            state_q <= state_d;
            dbg_unused_n <= '0;
            held_q <= held_d;
            dec_q <= dec_d;
            local_q <= local_d;
            merged_q <= merged_d;
            tgt_retry_q <= tgt_retry_d;
            tgt_done_q <= tgt_done_d;
            tgt_rdata_q <= tgt_rdata_d;
            bus_req_q <= bus_req_d;
            fwd_valid_q <= fwd_valid_d;
            fwd_q <= fwd_d;
            leg_valid_q <= leg_valid_d;
            leg_q <= leg_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    first_retry_a: assert property (
        (state_q == DDR_IDLE && tgt_valid && in_dist) |=> tgt_retry_q && !tgt_done_q)
        else $error("distributed access not retried");
    grant_first_a: assert property (
        (state_q == DDR_BUS_REQ && !bus_gnt) |=> !fwd_valid_q)
        else $error("forwarded cycle before grant");
    fwd_address_a: assert property (
        $rose(fwd_valid_q) |-> fwd_q.addr == fwd_addr(dec_q, $past(ptr_low), $past(ptr_high)))
        else $error("forwarded address wrong");
    stride_a: assert property (
        fwd_valid_q |-> fwd_q.addr[5:4] == (dec_q.chan[2] ? 2'(dec_q.chan[1:0] - 2'h1)
            : dec_q.chan[1:0]))
        else $error("channel slot wrong");
    read_repeat_a: assert property (
        (state_q == DDR_HOLD && repeat_hit && !held_q.write)
            |=> tgt_done_q && tgt_rdata_q == $past(merged_q))
        else $error("repeated read lost data");
    write_repeat_a: assert property (
        (state_q == DDR_HOLD && repeat_hit && held_q.write)
            |=> tgt_done_q ##1 !fwd_valid_q && !bus_req_q)
        else $error("repeated write not completed");
    local_chan_a: assert property (
        fwd_valid_q |-> dec_q.chan != `DDR_LOCAL_CHAN)
        else $error("channel four forwarded");
    write_data_a: assert property (
        (fwd_valid_q && fwd_q.write) |-> fwd_q.data == held_q.data)
        else $error("forwarded write data changed");
    save_mode_a: assert property (
        (state_q == DDR_IDLE && tgt_valid && alt_access) |=> !tgt_retry_q)
        else $error("state save access retried");
    busy_retry_a: assert property (
        (state_q inside {DDR_BUS_REQ, DDR_FORWARD} && tgt_valid) |=> tgt_retry_q)
        else $error("pending access not retried");
    direct_local_a: assert property (
        (state_q == DDR_IDLE && tgt_valid && in_dec.hit && !in_dist)
            |=> leg_valid_q && !tgt_retry_q)
        else $error("local access not passed on");

    // retry, handshake, forwarding, merge, local data and decode checks
    hold_retry_a: assert property (
        (state_q == DDR_HOLD && tgt_valid && !repeat_hit) |=> tgt_retry_q && !tgt_done_q)
        else $error("mismatched repeat not retried");
    pulse_excl_a: assert property (
        !(tgt_retry_q && tgt_done_q))
        else $error("retry and completion together");
    bus_kept_a: assert property (
        fwd_valid_q |-> bus_req_q)
        else $error("forwarded cycle without bus request");
    fwd_steady_a: assert property (
        (fwd_valid_q && !fwd_ack) |=> fwd_valid_q && $stable(fwd_q))
        else $error("forwarded cycle changed before acknowledge");
    fwd_once_a: assert property (
        (fwd_valid_q && fwd_ack) |=> !fwd_valid_q && !bus_req_q && state_q == DDR_HOLD)
        else $error("forwarded cycle not ended after acknowledge");
    hold_quiet_a: assert property (
        state_q == DDR_HOLD |-> !fwd_valid_q && !bus_req_q && !leg_valid_q)
        else $error("bus activity while holding result");
    write_rdata_a: assert property (
        (state_q == DDR_HOLD && repeat_hit && held_q.write) |=> tgt_rdata_q == 16'h0000)
        else $error("repeated write returned data");
    read_local_a: assert property (
        (state_q == DDR_IDLE && tgt_valid && in_dist && !tgt_req.write)
            |=> leg_valid_q && !bus_req_q && leg_q.addr == $past(tgt_req.addr))
        else $error("distributed read skipped local value");
    write_remote_a: assert property (
        (state_q == DDR_IDLE && tgt_valid && in_dist && tgt_req.write)
            |=> bus_req_q && !leg_valid_q)
        else $error("distributed write sent to local controller");
    merge_low_a: assert property (
        (fwd_valid_q && fwd_ack && !fwd_q.write) |=> merged_q[7:0] == $past(fwd_rdata[7:0]))
        else $error("peripheral byte lost in merge");
    merge_high_a: assert property (
        (fwd_valid_q && fwd_ack && !fwd_q.write && dec_q.kind == DDR_KIND_UPPER)
            |=> merged_q[15:8] == local_q[15:8])
        else $error("local byte lost in merge");
    merge_word_a: assert property (
        (fwd_valid_q && fwd_ack && !fwd_q.write && dec_q.kind != DDR_KIND_UPPER)
            |=> merged_q[15:8] == $past(fwd_rdata[15:8]))
        else $error("peripheral word lost in merge");
    local_data_a: assert property (
        (state_q == DDR_LEG_DIRECT && leg_ack && !held_q.write)
            |=> tgt_done_q && tgt_rdata_q == $past(leg_rdata))
        else $error("local read data lost");
    upper_index_a: assert property (
        (fwd_valid_q && dec_q.kind == DDR_KIND_UPPER) |-> fwd_q.addr[3:0] == `DDR_IDX_UPPER)
        else $error("upper address register index wrong");
    ptr_base_a: assert property (
        ($rose(fwd_valid_q) && dec_q.chan[2]) |-> fwd_q.addr[15:6] == $past(ptr_high))
        else $error("high group pointer not used");
    addr_port_a: assert property (
        (tgt_valid && tgt_req.addr == `DDR_CH6_ADDR_PORT)
            |-> in_dec.hit && in_dec.kind == DDR_KIND_ADDR && in_dec.chan == 3'h6)
        else $error("address port decoded wrongly");
    count_port_a: assert property (
        (tgt_valid && tgt_req.addr == `DDR_CH3_COUNT_PORT)
            |-> in_dec.hit && in_dec.kind == DDR_KIND_COUNT && in_dec.chan == 3'h3)
        else $error("count port decoded wrongly");
    upper_port_a: assert property (
        (tgt_valid && tgt_req.addr == `DDR_CH0_UPPER_PORT)
            |-> in_dec.hit && in_dec.kind == DDR_KIND_UPPER && in_dec.chan == 3'h0)
        else $error("upper address port decoded wrongly");

    dist_read_c: cover property (
        (state_q == DDR_HOLD && repeat_hit && !held_q.write) ##1 tgt_done_q);
    dist_write_c: cover property (
        (state_q == DDR_HOLD && repeat_hit && held_q.write) ##1 tgt_done_q);
    local_path_c: cover property (state_q == DDR_LEG_DIRECT && leg_ack);
    save_mode_c: cover property (tgt_valid && alt_access && in_dec.hit);
    held_retry_c: cover property (
        (state_q == DDR_HOLD && tgt_valid && !repeat_hit) ##1 tgt_retry_q);
endmodule

/* File: ddr_far_model.sv */
// far side model: bus arbiter, forwarded peripheral cycles and local controller
`timescale 1ns/100ps
module ddr_far_model (
    input wire logic clock,                    // clock
    input wire logic rst_n,                    // reset, active low
    input wire logic slow,                     // stretch grant and acknowledge
    input wire logic bus_req_q,                // bus request
    output logic bus_gnt,                      // bus granted
    input wire logic fwd_valid_q,              // forwarded cycle pending
    input wire ddr_pkg::ddr_access_t fwd_q,    // forwarded cycle
    output logic fwd_ack,                      // forwarded cycle finished
    output logic [15:0] fwd_rdata,             // peripheral read data
    input wire logic leg_valid_q,              // local access pending
    input wire ddr_pkg::ddr_access_t leg_q,    // local access
    output logic leg_ack,                      // local access finished
    output logic [15:0] leg_rdata,             // local read data
    output logic [15:0] fwd_count,             // forwarded cycles seen
    output ddr_pkg::ddr_access_t last_fwd,     // last forwarded cycle
    output logic early                         // forwarded cycle seen without grant
);
    import ddr_pkg::*;
    logic [3:0] gwait;
    logic [3:0] fwait;
    logic [3:0] lwait;
    logic [3:0] lat;
    assign lat = slow ? 4'h4 : 4'h0;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bus_gnt <= 1'b0;
            fwd_ack <= 1'b0;
            leg_ack <= 1'b0;
            fwd_rdata <= 16'hffff;
            leg_rdata <= 16'hffff;
            fwd_count <= 16'h0000;
            last_fwd <= '0;
            early <= 1'b0;
            gwait <= 4'h0;
            fwait <= 4'h0;
            lwait <= 4'h0;
        end else begin
            fwd_ack <= 1'b0;
            leg_ack <= 1'b0;
            // released data lines toggle so stale values never pass
            fwd_rdata <= ~fwd_rdata;
            leg_rdata <= ~leg_rdata;
            gwait <= bus_req_q ? gwait + 4'h1 : 4'h0;
            bus_gnt <= bus_req_q && (bus_gnt || gwait >= lat);
            if (fwd_valid_q && !bus_gnt)
                early <= 1'b1;
            if (fwd_valid_q && !fwd_ack && bus_gnt) begin
                if (fwait >= lat) begin
                    fwd_ack <= 1'b1;
                    fwd_rdata <= 16'ha5c3 ^ fwd_q.addr;
                    fwd_count <= fwd_count + 16'h0001;
                    last_fwd <= fwd_q;
                    fwait <= 4'h0;
                end else
                    fwait <= fwait + 4'h1;
            end
            if (leg_valid_q && !leg_ack) begin
                if (lwait >= lat) begin
                    leg_ack <= 1'b1;
                    leg_rdata <= 16'h3cf0 ^ leg_q.addr;
                    lwait <= 4'h0;
                end else
                    lwait <= lwait + 4'h1;
            end
        end
    end
endmodule

/* File: distributed_dma_register_redirect_test.sv */
// testbench of the distributed channel redirect
`timescale 1ns/100ps
module distributed_dma_register_redirect_test;
    import ddr_pkg::*;
    localparam logic [7:0] PA [21] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
        8'h07, 8'h81, 8'h82, 8'h83, 8'h87, 8'h89, 8'h8a, 8'h8b, 8'hc4, 8'hc6, 8'hc8, 8'hca,
        8'hcc, 8'hce};
    localparam int SL [21] = '{0, 0, 1, 1, 2, 2, 3, 3, 2, 3, 1, 0, 1, 2, 0, 0, 0, 1, 1, 2, 2};
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic tgt_valid = 1'b0;
    ddr_access_t tgt_req = '0;
    logic tgt_retry_q, tgt_done_q, bus_req_q, bus_gnt, fwd_valid_q, fwd_ack;
    logic leg_valid_q, leg_ack, early;
    logic [15:0] tgt_rdata_q, fwd_rdata, leg_rdata, fwd_count;
    ddr_access_t fwd_q, leg_q, last_fwd;
    logic [7:0] dist_en = 8'hff;
    logic [15:6] ptr_low = 10'h2a5;
    logic [15:6] ptr_high = 10'h13c;
    logic alt_access = 1'b0;
    logic slow = 1'b0;
    int num_errors = 0;
    int cmp_count = 0;
    always #2.5 clock = ~clock;
    ddr_redirect u_ddr_redirect (.clock, .rst_n, .tgt_valid, .tgt_req, .dbg_unused_n(),
        .tgt_retry_q, .tgt_done_q, .tgt_rdata_q, .dist_en, .ptr_low, .ptr_high, .alt_access,
        .bus_req_q, .bus_gnt, .fwd_valid_q, .fwd_q, .fwd_ack, .fwd_rdata, .leg_valid_q,
        .leg_q, .leg_ack, .leg_rdata);
    ddr_far_model u_ddr_far_model (.clock, .rst_n, .slow, .bus_req_q, .bus_gnt, .fwd_valid_q,
        .fwd_q, .fwd_ack, .fwd_rdata, .leg_valid_q, .leg_q, .leg_ack, .leg_rdata, .fwd_count,
        .last_fwd, .early);
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic int ix(input int i);
        return i < 8 ? (i % 2) * 2 : (i < 15 ? 4 : ((i - 15) % 2) * 2);
    endfunction
    function automatic logic [15:0] fwd_addr(input int i);
        logic [15:0] base;
        base = (i >= 12) ? {ptr_high, 6'h00} : {ptr_low, 6'h00};
        return base + 16'(SL[i] * 16) + 16'(ix(i));
    endfunction
    // one processor attempt, then wait for its retry or completion
    task automatic attempt(input logic w, input logic [15:0] a, input logic [15:0] d,
                           output logic rt, output logic dn, output logic [15:0] rd);
        int n;
        @(posedge clock);
        tgt_valid <= 1'b1;
        tgt_req <= '{w, a, d};
        @(posedge clock);
        tgt_valid <= 1'b0;
        rt = 1'b0;
        dn = 1'b0;
        rd = 16'h0000;
        for (n = 0; n < 60 && !rt && !dn; n++) begin
            @(negedge clock);
            rt = tgt_retry_q === 1'b1;
            dn = tgt_done_q === 1'b1;
            rd = tgt_rdata_q;
        end
    endtask
    task automatic dist_op(input int i, input logic w, input logic [15:0] d);
        logic rt, dn;
        logic [15:0] rd, per, lv, c0;
        int k;
        c0 = fwd_count;
        attempt(w, {8'h00, PA[i]}, d, rt, dn, rd);
        check({14'h0, rt, dn}, 16'h2);
        for (k = 0; k < 40 && !dn; k++)
            attempt(w, {8'h00, PA[i]}, d, rt, dn, rd);
        check(16'(dn), 16'h1);
        check(fwd_count - c0, 16'h1);
        check(last_fwd.addr, fwd_addr(i));
        check(16'(last_fwd.write), 16'(w));
        per = 16'ha5c3 ^ fwd_addr(i);
        lv = 16'h3cf0 ^ {8'h00, PA[i]};
        if (w)
            check(last_fwd.data, d);
        else
            check(rd, ix(i) == 4 ? {lv[15:8], per[7:0]} : per);
    endtask
    task automatic local_op(input logic [15:0] a, input logic w);
        logic rt, dn;
        logic [15:0] rd, c0;
        c0 = fwd_count;
        attempt(w, a, 16'h5aa5, rt, dn, rd);
        check({14'h0, rt, dn}, 16'h1);
        check(fwd_count, c0);
        if (!w)
            check(rd, 16'h3cf0 ^ a);
    endtask
    initial begin
        logic rt, dn;
        logic [15:0] rd, c0;
        int k;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 21; i++) begin
            @(posedge clock);
            slow <= 1'(i % 2);
            dist_op(i, 1'b1, 16'h1200 + 16'(i));
            dist_op(i, 1'b0, 16'h0000);
        end
        $display("test port map done");
        @(posedge clock);
        slow <= 1'b1;
        c0 = fwd_count;
        attempt(1'b0, 16'h0000, 16'h0000, rt, dn, rd);
        for (k = 0; k < 200 && fwd_count == c0; k++)
            @(posedge clock);
        repeat (4) @(posedge clock);
        attempt(1'b1, 16'h0002, 16'h7777, rt, dn, rd);
        check({14'h0, rt, dn}, 16'h2);
        attempt(1'b0, 16'h0000, 16'h0000, rt, dn, rd);
        check({14'h0, rt, dn}, 16'h1);
        check(rd, 16'ha5c3 ^ fwd_addr(0));
        check(fwd_count - c0, 16'h1);
        $display("test held access done");
        @(posedge clock);
        dist_en <= 8'h20;
        local_op(16'h00c8, 1'b0);
        local_op(16'h0087, 1'b1);
        dist_op(15, 1'b0, 16'h0000);
        @(posedge clock);
        dist_en <= 8'hff;
        alt_access <= 1'b1;
        local_op(16'h0000, 1'b0);
        local_op(16'h00ce, 1'b0);
        local_op(16'h0083, 1'b1);
        @(posedge clock);
        alt_access <= 1'b0;
        check(16'(early), 16'h0);
        $display("test local and state save done");
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clock);
        num_errors++;
        wrap_up();
    end
endmodule
